/* File: dv/clear_complement_decrement_ops_bench.sv */
`timescale 1ns/1ps
module clear_complement_decrement_ops_bench
    import op_exec_pkg::*;
;
    logic clk_sys = 0;
    logic reset = 1;
    instr_s instr = '0;
    logic watchdog_tick = 0;
    logic [7:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic [7:0] reg_rdata;
    core_flags_s flags;
    logic [7:0] accumulator;
    logic [7:0] watchdog_counter;
    logic done;
    int err_count = 0;
    int total_checks = 0;
    int acc_m = 0;
    int zero_m = 0;
    int file_m [128];
    logic [31:0] rnd = 32'h46A8;
    // Free-running core clock.
    always #2.5 clk_sys = ~clk_sys;
    op_exec DUT (.clk_sys, .reset, .instr, .watchdog_tick, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .flags, .accumulator, .watchdog_counter, .done);
    // Pseudo-random source for addresses, data and op choice.
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Compares one byte result.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Register port cycles; read data are sampled in the cycle after the strobe.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
    endtask
    // Issues one op word and checks the result one cycle later.
    task automatic run_op(input logic [13:0] w);
        @(posedge clk_sys);
        instr <= {1'b1, w};
        @(posedge clk_sys);
        instr <= '0;
        #1;
        chk("done", 8'h01, {7'h00, done});
        chk("acc", acc_m[7:0], accumulator);
        chk("zero", zero_m[7:0], {7'h00, flags.zero_flag});
    endtask
    task automatic file_op(input bit dec, input bit d, input logic [6:0] a);
        int r;
        r = dec ? (file_m[a] - 1) & 255 : ~file_m[a] & 255;
        zero_m = (r == 0);
        if (d)
            file_m[a] = r;
        else
            acc_m = r;
        run_op({dec ? 6'h03 : 6'h09, d, a});
        rd_reg({1'b1, a});
        chk("file", file_m[a][7:0], reg_rdata);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence.
    initial
    begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        rd_reg(8'h01);
        chk("status", 8'h18, reg_rdata);
        chk("flags", 8'h03, {6'h00, flags[1:0]});
        for (int i = 0; i < 12; i++)
        begin
            rnd = lfsr(rnd);
            file_m[rnd[6:0]] = (i < 2) ? i : rnd[15:8];
            wr_reg({1'b1, rnd[6:0]}, file_m[rnd[6:0]][7:0]);
            file_op(i < 2 || rnd[16], rnd[17], rnd[6:0]);
            file_op(rnd[18], rnd[19], rnd[6:0]);
        end
        $display("file ops done");
        wr_reg(8'h00, 8'h5A);
        wr_reg(8'h01, 8'h00);
        acc_m = 0;
        zero_m = 1;
        run_op(14'h0103);
        $display("clear done");
        wr_reg(8'h03, 8'h5A);
        wr_reg(8'h01, 8'h00);
        zero_m = 0;
        @(posedge clk_sys);
        watchdog_tick <= 1'b1;
        repeat (5) @(posedge clk_sys);
        watchdog_tick <= 1'b0;
        #1;
        chk("watchdog", 8'h05, watchdog_counter);
        chk("flags", 8'h00, {6'h00, flags[1:0]});
        run_op(14'h0064);
        chk("watchdog", 8'h00, watchdog_counter);
        chk("flags", 8'h03, {6'h00, flags[1:0]});
        rd_reg(8'h03);
        chk("prescaler", 8'h00, reg_rdata);
        rd_reg(8'h01);
        chk("status", 8'h18, reg_rdata);
        $display("watchdog done");
        tally_and_finish();
    end
    // Cuts a hang short.
    initial
    begin
        #100000;
        err_count++;
        tally_and_finish();
    end
endmodule

/* File: dv/op_exec_props.sv */
`timescale 1ns/1ps
module op_exec_props
    import op_exec_pkg::*;
(
    // Watched ports.
    input wire logic clk_sys,
    input wire logic reset,
    input wire instr_s instr,
    input wire logic watchdog_tick,
    input wire core_flags_s flags,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] watchdog_counter,
    input wire logic done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Decoded operations as seen at the port.
    wire logic clr = instr.valid && instr.word[13:7] == 7'h02;
    wire logic wdc = instr.valid && instr.word == 14'h0064;
    wire logic cmf = instr.valid && instr.word[13:8] == 6'h09;
    wire logic dcf = instr.valid && instr.word[13:8] == 6'h03;
    chk_clear_acc: assert property (clr |=> accumulator == 8'h00 && flags.zero_flag)
        else $error("accumulator clear wrong");
    chk_watchdog_clear: assert property (wdc |=> watchdog_counter == 8'h00 && flags[1:0] == 2'h3)
        else $error("watchdog clear wrong");
    chk_watchdog_hold: assert property (wdc ##1 !watchdog_tick [*2] |=> watchdog_counter == 8'h00)
        else $error("watchdog not held");
    chk_comp_zero: assert property (cmf && !instr.word[7] |=> flags.zero_flag == !accumulator)
        else $error("complement zero wrong");
    chk_dec_zero: assert property (dcf && !instr.word[7] |=> flags.zero_flag == !accumulator)
        else $error("decrement zero wrong");
    chk_file_dest: assert property ((cmf || dcf) && instr.word[7] |=> $stable(accumulator))
        else $error("file result reached accumulator");
    chk_one_cycle: assert property (clr || wdc || cmf || dcf |=> done)
        else $error("done missing");
    chk_idle_done: assert property (!instr.valid |=> !done)
        else $error("done without op");
    cover property (clr);
    cover property (wdc);
    cover property (dcf && instr.word[7]);
    cover property (cmf && !instr.word[7]);
endmodule
bind op_exec op_exec_props u_props (.clk_sys, .reset, .instr, .watchdog_tick, .flags,
    .accumulator, .watchdog_counter, .done);

/* File: rtl/op_exec.sv */
// Overview of operation
// - Clear accumulator op zeroes accumulator, sets zero.
// - Complement op inverts file register, updates zero.
// - Destination bit zero to accumulator, one to file.
// - Watchdog clear zeroes counter, prescaler, sets status.
// - Decrement op subtracts one, updates zero flag.
`timescale 1ns/1ps
`include "op_exec_params.svh"

module op_exec
    import op_exec_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Instruction stream, one word per cycle.
    input wire instr_s instr,
    // Watchdog advance pulse from the clock source.
    input wire logic watchdog_tick,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Core state.
    output core_flags_s flags,
    output logic [7:0] accumulator,
    output logic [7:0] watchdog_counter,
    output logic done
);

    // File registers, one byte per address; contents are not reset.
    logic [7:0] file_mem [0:`FILE_DEPTH-1];
    // Accumulator and zero flag.
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    logic zero_r;
    logic zero_nxt;
    // Watchdog counter and its prescaler.
    logic [7:0] wdog_r;
    logic [7:0] wdog_nxt;
    logic [7:0] pre_r;
    logic [7:0] pre_nxt;
    // Time-out and power-down status.
    logic tout_r;
    logic tout_nxt;
    logic pdown_r;
    logic pdown_nxt;
    // Completion pulse.
    logic done_r;
    logic done_nxt;
    // Register read data.
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    // File register write port.
    logic file_we;
    logic [6:0] file_waddr;
    logic [7:0] file_wdata;
    // Decoded instruction and its operand.
    op_kind_e kind;
    logic [6:0] faddr;
    logic [7:0] fval;
    logic [7:0] result;
    logic dest_file;
    logic is_file_op;
    // Register port writes that are taken this cycle.
    logic ctl_wr;
    logic file_wr;

    // Classifies an instruction word into an operation kind.
    function automatic op_kind_e decode(input logic [13:0] w);
        if (w == `OPW_WATCHDOG_CLEAR)
            return watchdog_clear_op;
        else if (w[`OPC7_MSB:`OPC7_LSB] == `OPC7_CLEAR_ACC)
            return clear_accumulator_op;
        else if (w[`OPC6_MSB:`OPC6_LSB] == `OPC6_COMPLEMENT)
            return complement_file_op;
        else if (w[`OPC6_MSB:`OPC6_LSB] == `OPC6_DECREMENT)
            return decrement_file_op;
        else
            return op_none;
    endfunction

    // Tells whether a port address falls in the file register window.
    function automatic logic in_file(input logic [7:0] a);
        return a[`FILE_SEL_BIT];
    endfunction

    // File register index of a port address inside the window.
    function automatic logic [6:0] file_index(input logic [7:0] a);
        return a[`ADDR_MSB:0];
    endfunction

    // Decode of the presented word; an idle slot decodes to no operation.
    assign kind = instr.valid ? decode(instr.word) : op_none;
    assign faddr = instr.word[`ADDR_MSB:0];
    assign fval = file_mem[faddr];
    assign dest_file = instr.word[`DEST_BIT];
    assign is_file_op = kind == complement_file_op || kind == decrement_file_op;

    // Port writes are dropped whenever an operation is taken at the same edge.
    assign ctl_wr = reg_wr && kind == op_none && !in_file(reg_addr);
    assign file_wr = reg_wr && kind == op_none && in_file(reg_addr);

    // Result of a file operation, shared by both destinations.
    always_comb
    begin
        result = `ZERO_BYTE;
        case (kind)
            complement_file_op: result = ~fval;
            decrement_file_op: result = fval - `DEC_STEP;
            default: result = `ZERO_BYTE;
        endcase
    end

    // Accumulator and zero flag; every operation finishes in this cycle.
    always_comb
    begin
        acc_nxt = acc_r;
        zero_nxt = zero_r;
        case (kind)
            clear_accumulator_op:
            begin
                acc_nxt = `ZERO_BYTE;
                zero_nxt = `FLAG_SET;
            end
            complement_file_op, decrement_file_op:
            begin
                zero_nxt = result == `ZERO_BYTE;
                if (!dest_file)
                    acc_nxt = result;
            end
            default:
            begin
                if (ctl_wr && reg_addr == `REG_ACCUMULATOR)
                    acc_nxt = reg_wdata;
                if (ctl_wr && reg_addr == `REG_STATUS)
                    zero_nxt = reg_wdata[`STATUS_ZERO_BIT];
            end
        endcase
    end

    // Accumulator and zero flag registers.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            acc_r <= `ZERO_BYTE;
            zero_r <= `FLAG_CLEAR;
        end
        else
        begin
            acc_r <= acc_nxt;
            zero_r <= zero_nxt;
        end
    end

    // Watchdog counter and prescaler; a clear beats a tick in the same cycle.
    always_comb
    begin
        wdog_nxt = wdog_r;
        pre_nxt = pre_r;
        if (kind == watchdog_clear_op)
        begin
            wdog_nxt = `WATCHDOG_ZERO;
            pre_nxt = `PRESCALER_ZERO;
        end
        else
        begin
            if (watchdog_tick)
                wdog_nxt = wdog_r + `WATCHDOG_STEP;
            if (ctl_wr && reg_addr == `REG_PRESCALER)
                pre_nxt = reg_wdata;
        end
    end

    // Watchdog counter and prescaler registers.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            wdog_r <= `WATCHDOG_ZERO;
            pre_r <= `PRESCALER_ZERO;
        end
        else
        begin
            wdog_r <= wdog_nxt;
            pre_r <= pre_nxt;
        end
    end

    // Time-out and power-down status; the watchdog clear sets both.
    always_comb
    begin
        tout_nxt = tout_r;
        pdown_nxt = pdown_r;
        if (kind == watchdog_clear_op)
        begin
            tout_nxt = `FLAG_SET;
            pdown_nxt = `FLAG_SET;
        end
        else if (ctl_wr && reg_addr == `REG_STATUS)
        begin
            tout_nxt = reg_wdata[`STATUS_TOUT_BIT];
            pdown_nxt = reg_wdata[`STATUS_PDOWN_BIT];
        end
    end

    // Status flag registers; both come out of reset set.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            tout_r <= `FLAG_SET;
            pdown_r <= `FLAG_SET;
        end
        else
        begin
            tout_r <= tout_nxt;
            pdown_r <= pdown_nxt;
        end
    end

    // Completion pulse for any recognised operation.
    always_comb
    begin
        done_nxt = kind != op_none;
    end

    // Completion pulse register; high for exactly one cycle per operation.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            done_r <= `FLAG_CLEAR;
        else
            done_r <= done_nxt;
    end

    // Register read data, shown in the cycle after the read strobe only.
    always_comb
    begin
        rdata_nxt = `ZERO_BYTE;
        if (reg_rd)
        begin
            if (in_file(reg_addr))
                rdata_nxt = file_mem[file_index(reg_addr)];
            else
            begin
                case (reg_addr)
                    `REG_ACCUMULATOR: rdata_nxt = acc_r;
                    `REG_STATUS:
                    begin
                        rdata_nxt[`STATUS_ZERO_BIT] = zero_r;
                        rdata_nxt[`STATUS_PDOWN_BIT] = pdown_r;
                        rdata_nxt[`STATUS_TOUT_BIT] = tout_r;
                    end
                    `REG_WATCHDOG: rdata_nxt = wdog_r;
                    `REG_PRESCALER: rdata_nxt = pre_r;
                    default: rdata_nxt = `ZERO_BYTE;
                endcase
            end
        end
    end

    // Read data register; it falls back to zero when no read was made.
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            rdata_r <= `ZERO_BYTE;
        else
            rdata_r <= rdata_nxt;
    end

    // File write port; an operation result has priority over a port write.
    always_comb
    begin
        file_we = 1'b0;
        file_waddr = faddr;
        file_wdata = `ZERO_BYTE;
        if (is_file_op && dest_file)
        begin
            file_we = 1'b1;
            file_wdata = result;
        end
        else if (file_wr)
        begin
            file_we = 1'b1;
            file_waddr = file_index(reg_addr);
            file_wdata = reg_wdata;
        end
    end

    // File register array; a following operation sees the new value.
    always_ff @(posedge clk_sys)
    begin
        if (file_we)
            file_mem[file_waddr] <= file_wdata;
    end

    // Outputs straight from the state registers.
    assign reg_rdata = rdata_r;
    assign accumulator = acc_r;
    assign watchdog_counter = wdog_r;
    assign flags = '{zero_flag: zero_r, timeout_status_flag: tout_r,
                     powerdown_status_flag: pdown_r};
    assign done = done_r;

endmodule

/* File: rtl/op_exec_params.svh */
`ifndef OP_EXEC_PARAMS_SVH
`define OP_EXEC_PARAMS_SVH

// Opcode layout of the 14-bit instruction word.
`define OPW_WIDTH 14
`define DATA_WIDTH 8
`define ADDR_WIDTH 7
`define FILE_DEPTH 128
`define DEST_BIT 7
`define ADDR_MSB 6
`define OPC6_MSB 13
`define OPC6_LSB 8
`define OPC7_MSB 13
`define OPC7_LSB 7
// Six-bit major codes for the file operations.
`define OPC6_COMPLEMENT 6'h09
`define OPC6_DECREMENT 6'h03
// Seven-bit code of the accumulator clear.
`define OPC7_CLEAR_ACC 7'h02
// Full word of the watchdog clear.
`define OPW_WATCHDOG_CLEAR 14'h0064
// Reset and clear values.
`define ZERO_BYTE 8'h00
`define WATCHDOG_WIDTH 8
`define PRESCALER_WIDTH 8
`define WATCHDOG_ZERO 8'h00
`define PRESCALER_ZERO 8'h00
`define FLAG_SET 1'b1

// Register port offsets.
`define REG_ACCUMULATOR 8'h00
`define REG_STATUS 8'h01
`define REG_WATCHDOG 8'h02
`define REG_PRESCALER 8'h03
`define REG_FILE_BASE 8'h80
`define STATUS_ZERO_BIT 0
`define STATUS_PDOWN_BIT 3
`define STATUS_TOUT_BIT 4
// Address bit that selects the file register window.
`define FILE_SEL_BIT 7
// Steps of the decrement and of the watchdog advance.
`define DEC_STEP 8'h01
`define WATCHDOG_STEP 8'h01
`define FLAG_CLEAR 1'b0

`endif

/* File: rtl/op_exec_pkg.sv */
package op_exec_pkg;
    // Decoded operation kinds.
    typedef enum logic [2:0] {
        op_none,
        clear_accumulator_op,
        complement_file_op,
        decrement_file_op,
        watchdog_clear_op
    } op_kind_e;

    // Instruction presented to the execution stage.
    typedef struct packed {
        logic valid;
        logic [13:0] word;
    } instr_s;

    // Core status outputs.
    typedef struct packed {
        logic zero_flag;
        logic timeout_status_flag;
        logic powerdown_status_flag;
    } core_flags_s;
endpackage
